/* enpin_pkg.sv */
// Shared constants for the enable pin supply assignment block.
// Assumes an 8-bit register port and pin levels synchronous to clk.
package enpin_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] SMPS_PIN1_ASSIGN_OFS = 8'h46;
  localparam logic [7:0] LINREG_PIN2_ASSIGN_OFS = 8'h47;

  // Widths of the register port and of the assignment registers.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CONV_N = 4;
  localparam int LINREG_N = 8;

  // Field positions in the switching supply assignment register.
  localparam int IO_SUPPLY_BIT = 0;
  localparam int CORE1_BIT = 1;
  localparam int CORE2_BIT = 2;
  localparam int EXT_FET_BIT = 3;
  localparam int SPARE_BIT = 4;
  localparam int SMPS_STORED_W = 5;
  localparam int SMPS_RSVD_W = 3;

  // Values after reset of both assignment registers and of the read data, and the unmapped read value.
  localparam logic [SMPS_STORED_W-1:0] SMPS_PIN1_ASSIGN_RST = 5'h00;
  localparam logic [LINREG_N-1:0] LINREG_PIN2_ASSIGN_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_DATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

  // Regulator number held by each linear regulator assignment bit, bit 0 first.
  localparam int LINREG_OF_BIT [LINREG_N] = '{6, 1, 2, 5, 8, 7, 4, 3};

  // Per converter options, indexed by assignment bit: voltage scaled and low-power capable.
  localparam logic [CONV_N-1:0] CONV_VOLT_SCALED = 4'hE;
  localparam logic [CONV_N-1:0] CONV_LP_CAPABLE = 4'h7;

endpackage : enpin_pkg

/* converter_pin_select.sv */
// One switching converter's choice between register control and first pin control.
// Assumes the voltage code of all zeros means the supply is commanded off.
`timescale 1ns/1ps
module converter_pin_select #(
  parameter int VOLT_W = 8,
  parameter bit VOLT_SCALED = 1'b1,
  parameter bit LP_CAPABLE = 1'b1
) (
  input wire logic assigned,
  input wire logic pin,
  input wire logic keep_on,
  input wire logic reg_on,
  input wire logic reg_lp,
  input wire logic [VOLT_W-1:0] reg_volt,
  input wire logic [VOLT_W-1:0] op_volt,
  input wire logic [VOLT_W-1:0] alt_volt,
  output logic on,
  output logic low_power,
  output logic [VOLT_W-1:0] volt
);
  import enpin_pkg::*;

  localparam logic [VOLT_W-1:0] VOLT_OFF = '0;

  logic [VOLT_W-1:0] sel_volt;
  logic pin_on;
  logic pin_lp;
  logic [VOLT_W-1:0] pin_volt;

  // A high pin picks the operating voltage, a low pin the alternate one.
  // pin picks voltage.
  assign sel_volt = pin ? op_volt : alt_volt;

  // Scaled converters run while the chosen voltage is not off; the I/O converter is on with the pin or kept on.
  // on and low-power.
  assign pin_on = VOLT_SCALED ? (sel_volt != VOLT_OFF) : (pin | keep_on);
  assign pin_lp = LP_CAPABLE & ~pin & keep_on & pin_on;
  assign pin_volt = VOLT_SCALED ? sel_volt : reg_volt;

  // An unassigned converter ignores the pin entirely.
  // register fallback.
  assign on = assigned ? pin_on : reg_on;
  assign low_power = assigned ? pin_lp : reg_lp;
  assign volt = assigned ? pin_volt : reg_volt;

endmodule : converter_pin_select

/* enable_pin_assign.sv */
// Assignment registers that hand supplies over to the two enable pins, and the resulting supply states.
// Assumes pins and register inputs are synchronous to clk and nrst is the turn-off reset.
`timescale 1ns/1ps
module enable_pin_assign #(
  parameter int VOLT_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [enpin_pkg::ADDR_W-1:0] addr,
  input wire logic [enpin_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [enpin_pkg::DATA_W-1:0] rd_data,
  input wire logic enable_pin_one,
  input wire logic enable_pin_two,
  input wire logic [enpin_pkg::CONV_N-1:0] sleep_keep_converter_on,
  input wire logic [enpin_pkg::LINREG_N-1:0] sleep_keep_linreg_on,
  input wire logic [VOLT_W-1:0] ext_fet_operating_voltage,
  input wire logic [VOLT_W-1:0] ext_fet_alternate_voltage,
  input wire logic [VOLT_W-1:0] core1_operating_voltage,
  input wire logic [VOLT_W-1:0] core1_alternate_voltage,
  input wire logic [VOLT_W-1:0] core2_operating_voltage,
  input wire logic [VOLT_W-1:0] core2_alternate_voltage,
  input wire logic [enpin_pkg::CONV_N-1:0] conv_reg_on,
  input wire logic [enpin_pkg::CONV_N-1:0] conv_reg_lp,
  input wire logic [enpin_pkg::CONV_N-1:0][VOLT_W-1:0] conv_reg_volt,
  input wire logic [enpin_pkg::LINREG_N-1:0] linreg_reg_on,
  input wire logic [enpin_pkg::LINREG_N-1:0] linreg_reg_lp,
  output logic [enpin_pkg::CONV_N-1:0] conv_on,
  output logic [enpin_pkg::CONV_N-1:0] conv_low_power,
  output logic [enpin_pkg::CONV_N-1:0][VOLT_W-1:0] conv_voltage,
  output logic [enpin_pkg::LINREG_N-1:0] linreg_on,
  output logic [enpin_pkg::LINREG_N-1:0] linreg_low_power,
  output logic voltage_scaling_serial_port_enable
);
  import enpin_pkg::*;

  logic [SMPS_STORED_W-1:0] smps_pin1_assign_r;
  logic [LINREG_N-1:0] linreg_pin2_assign_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic [CONV_N-1:0] conv_on_r;
  logic [CONV_N-1:0] conv_lp_r;
  logic [CONV_N-1:0][VOLT_W-1:0] conv_volt_r;
  logic [LINREG_N-1:0] linreg_on_r;
  logic [LINREG_N-1:0] linreg_lp_r;
  logic serial_enable_r;
  logic sel_smps;
  logic sel_linreg;
  logic [DATA_W-1:0] smps_rd_word;
  logic [CONV_N-1:0] conv_assigned;
  logic [CONV_N-1:0][VOLT_W-1:0] op_volt;
  logic [CONV_N-1:0][VOLT_W-1:0] alt_volt;
  logic [CONV_N-1:0] conv_on_nxt;
  logic [CONV_N-1:0] conv_lp_nxt;
  logic [CONV_N-1:0][VOLT_W-1:0] conv_volt_nxt;
  logic [LINREG_N-1:0] linreg_on_nxt;
  logic [LINREG_N-1:0] linreg_lp_nxt;
  logic any_assigned;

  // Address decode shared by the write and read paths.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign sel_smps = hit(addr, SMPS_PIN1_ASSIGN_OFS);
  assign sel_linreg = hit(addr, LINREG_PIN2_ASSIGN_OFS);

  assign smps_rd_word = {{SMPS_RSVD_W{1'b0}}, smps_pin1_assign_r};

  // Read mux; unmapped addresses answer zero.
  assign rd_data_nxt = sel_smps ? smps_rd_word : (sel_linreg ? linreg_pin2_assign_r : RD_UNMAPPED);

  // Switching supply assignment register; the spare bit steers no supply but clears the serial port enable.
  // turn-off reset clears it.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      smps_pin1_assign_r <= SMPS_PIN1_ASSIGN_RST;
    else if (wr_en && sel_smps)
      smps_pin1_assign_r <= wr_data[SMPS_STORED_W-1:0];
  end

  // Linear regulator assignment register, every bit read-write.
  // full byte stored.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      linreg_pin2_assign_r <= LINREG_PIN2_ASSIGN_RST;
    else if (wr_en && sel_linreg)
      linreg_pin2_assign_r <= wr_data;
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rd_data_r <= RD_DATA_RST;
    else if (rd_en)
      rd_data_r <= rd_data_nxt;
    else
      rd_data_r <= RD_DATA_RST;
  end

  // The spare bit is left out so it never steers a supply.
  // spare steers nothing.
  assign conv_assigned = smps_pin1_assign_r[CONV_N-1:0];

  // serial port off when any bit set.
  assign any_assigned = (|conv_assigned) | smps_pin1_assign_r[SPARE_BIT] | (|linreg_pin2_assign_r);

  // Voltage register pairs by converter; the I/O converter has none and uses its programmed voltage.
  // voltage register pairs.
  assign op_volt[IO_SUPPLY_BIT] = conv_reg_volt[IO_SUPPLY_BIT];
  assign alt_volt[IO_SUPPLY_BIT] = conv_reg_volt[IO_SUPPLY_BIT];
  assign op_volt[CORE1_BIT] = core1_operating_voltage;
  assign alt_volt[CORE1_BIT] = core1_alternate_voltage;
  assign op_volt[CORE2_BIT] = core2_operating_voltage;
  assign alt_volt[CORE2_BIT] = core2_alternate_voltage;
  assign op_volt[EXT_FET_BIT] = ext_fet_operating_voltage;
  assign alt_volt[EXT_FET_BIT] = ext_fet_alternate_voltage;

  // One selector per converter, options set from its bit position.
  // converters follow the first pin.
  generate
    for (genvar c = 0; c < CONV_N; c++)
    begin : g_conv
      converter_pin_select #(
        .VOLT_W(VOLT_W),
        .VOLT_SCALED(CONV_VOLT_SCALED[c]),
        .LP_CAPABLE(CONV_LP_CAPABLE[c])
      ) u_sel (
        .assigned(conv_assigned[c]),
        .pin(enable_pin_one),
        .keep_on(sleep_keep_converter_on[c]),
        .reg_on(conv_reg_on[c]),
        .reg_lp(conv_reg_lp[c]),
        .reg_volt(conv_reg_volt[c]),
        .op_volt(op_volt[c]),
        .alt_volt(alt_volt[c]),
        .on(conv_on_nxt[c]),
        .low_power(conv_lp_nxt[c]),
        .volt(conv_volt_nxt[c])
      );
    end
  endgenerate

  // Linear regulators under the second pin, keep-on selecting off or low-power while low.
  // regulators follow the second pin.
  generate
    for (genvar l = 0; l < LINREG_N; l++)
    begin : g_linreg
      assign linreg_on_nxt[l] = linreg_pin2_assign_r[l] ? (enable_pin_two | sleep_keep_linreg_on[l]) : linreg_reg_on[l];
      assign linreg_lp_nxt[l] = linreg_pin2_assign_r[l] ? (~enable_pin_two & sleep_keep_linreg_on[l]) : linreg_reg_lp[l];
    end
  endgenerate

  // Supply state outputs are registered for clean control lines.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      conv_on_r <= '0;
      conv_lp_r <= '0;
      conv_volt_r <= '0;
      linreg_on_r <= '0;
      linreg_lp_r <= '0;
      serial_enable_r <= 1'b1;
    end
    else
    begin
      conv_on_r <= conv_on_nxt;
      conv_lp_r <= conv_lp_nxt;
      conv_volt_r <= conv_volt_nxt;
      linreg_on_r <= linreg_on_nxt;
      linreg_lp_r <= linreg_lp_nxt;
      serial_enable_r <= ~any_assigned;
    end
  end

  // Output drive.
  assign rd_data = rd_data_r;
  assign conv_on = conv_on_r;
  assign conv_low_power = conv_lp_r;
  assign conv_voltage = conv_volt_r;
  assign linreg_on = linreg_on_r;
  assign linreg_low_power = linreg_lp_r;
  assign voltage_scaling_serial_port_enable = serial_enable_r;

  // Checks on the registered behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence smps_write_s;
    wr_en && sel_smps;
  endsequence

  sequence smps_read_s;
    rd_en && sel_smps;
  endsequence

  sequence core2_sleep_s;
    conv_assigned[CORE2_BIT] && !enable_pin_one && sleep_keep_converter_on[CORE2_BIT];
  endsequence

  sequence core1_sleep_s;
    conv_assigned[CORE1_BIT] && !enable_pin_one && sleep_keep_converter_on[CORE1_BIT];
  endsequence

  smps_readback_a: assert property (smps_write_s ##1 smps_read_s |=>
    rd_data == {3'h0, $past(wr_data[SMPS_STORED_W-1:0], 2)})
    else $error("switching assignment readback wrong");

  rsvd_zero_a: assert property (smps_read_s |=> rd_data[7:5] == 3'h0)
    else $error("reserved bits not zero");

  linreg_readback_a: assert property ((wr_en && sel_linreg) ##1 (rd_en && sel_linreg) |=> rd_data == $past(wr_data, 2))
    else $error("regulator assignment readback wrong");

  serial_disable_a: assert property (##1 voltage_scaling_serial_port_enable == !$past(any_assigned))
    else $error("serial port enable wrong");

  reset_clear_a: assert property ($rose(nrst) |-> smps_pin1_assign_r == 5'h00 && linreg_pin2_assign_r == 8'h00)
    else $error("assignment not cleared by reset");

  ext_fet_volt_a: assert property (conv_assigned[EXT_FET_BIT] |=>
    conv_voltage[EXT_FET_BIT] == ($past(enable_pin_one) ? $past(ext_fet_operating_voltage) : $past(ext_fet_alternate_voltage)))
    else $error("external FET voltage select wrong");

  core1_volt_a: assert property (conv_assigned[CORE1_BIT] && enable_pin_one |=> conv_voltage[CORE1_BIT] == $past(core1_operating_voltage))
    else $error("core one voltage select wrong");

  core2_volt_a: assert property (conv_assigned[CORE2_BIT] && !enable_pin_one |=> conv_voltage[CORE2_BIT] == $past(core2_alternate_voltage))
    else $error("core two voltage select wrong");

  core2_lowpower_a: assert property (core2_sleep_s |=> conv_low_power[CORE2_BIT] == ($past(core2_alternate_voltage) != '0))
    else $error("core two low-power wrong");

  core1_lowpower_a: assert property (core1_sleep_s |=>
    conv_low_power[CORE1_BIT] == ($past(core1_alternate_voltage) != '0))
    else $error("core one low-power wrong");

  io_on_a: assert property (conv_assigned[IO_SUPPLY_BIT] && enable_pin_one |=> conv_on[IO_SUPPLY_BIT] && !conv_low_power[IO_SUPPLY_BIT])
    else $error("I/O converter not on with pin high");

  io_sleep_a: assert property (conv_assigned[IO_SUPPLY_BIT] && !enable_pin_one |=>
    conv_on[IO_SUPPLY_BIT] == $past(sleep_keep_converter_on[IO_SUPPLY_BIT]) && conv_low_power[IO_SUPPLY_BIT] == conv_on[IO_SUPPLY_BIT])
    else $error("I/O converter sleep state wrong");

  conv_unassigned_a: assert property (!conv_assigned[CORE1_BIT] |=> conv_on[CORE1_BIT] == $past(conv_reg_on[CORE1_BIT]) &&
    conv_voltage[CORE1_BIT] == $past(conv_reg_volt[CORE1_BIT]))
    else $error("unassigned converter not register driven");

  linreg_high_a: assert property (linreg_pin2_assign_r[0] && enable_pin_two |=> linreg_on[0] && !linreg_low_power[0])
    else $error("regulator not on with pin high");

  linreg_off_a: assert property (linreg_pin2_assign_r[7] && !enable_pin_two && !sleep_keep_linreg_on[7] |=> !linreg_on[7])
    else $error("regulator not off with pin low");

  linreg_lowpower_a: assert property (linreg_pin2_assign_r[2] && !enable_pin_two && sleep_keep_linreg_on[2] |=>
    linreg_on[2] && linreg_low_power[2])
    else $error("regulator not low-power with pin low");

  linreg_unassigned_a: assert property (!linreg_pin2_assign_r[5] |=> linreg_on[5] == $past(linreg_reg_on[5]) &&
    linreg_low_power[5] == $past(linreg_reg_lp[5]))
    else $error("unassigned regulator not register driven");

  pin_effect_a: assert property (conv_assigned[CORE2_BIT] && enable_pin_one |=> conv_voltage[CORE2_BIT] == $past(core2_operating_voltage))
    else $error("assigned converter ignores first pin");

  linreg_follow_a: assert property (linreg_pin2_assign_r[5] |=> linreg_on[5] == ($past(enable_pin_two) || $past(sleep_keep_linreg_on[5])))
    else $error("assigned regulator ignores second pin");

  // Further checks on off commands, the spare and unmapped space, and idle read data.
  ext_fet_nolp_a: assert property (conv_assigned[EXT_FET_BIT] |=> !conv_low_power[EXT_FET_BIT])
    else $error("external FET entered low-power");

  ext_fet_off_a: assert property (conv_assigned[EXT_FET_BIT] && !enable_pin_one &&
    ext_fet_alternate_voltage == '0 |=> !conv_on[EXT_FET_BIT])
    else $error("external FET not off by alternate register");

  core2_on_a: assert property (conv_assigned[CORE2_BIT] |=>
    conv_on[CORE2_BIT] == ($past(enable_pin_one) ? $past(core2_operating_voltage) != '0 :
    $past(core2_alternate_voltage) != '0))
    else $error("core two on state wrong");

  core1_on_a: assert property (conv_assigned[CORE1_BIT] |=>
    conv_on[CORE1_BIT] == ($past(enable_pin_one) ? $past(core1_operating_voltage) != '0 :
    $past(core1_alternate_voltage) != '0))
    else $error("core one on state wrong");

  core1_alt_volt_a: assert property (conv_assigned[CORE1_BIT] && !enable_pin_one |=>
    conv_voltage[CORE1_BIT] == $past(core1_alternate_voltage))
    else $error("core one alternate voltage wrong");

  spare_inert_a: assert property (smps_pin1_assign_r[SPARE_BIT] && !(|conv_assigned) |=>
    conv_on == $past(conv_reg_on) && conv_low_power == $past(conv_reg_lp))
    else $error("spare bit steered a converter");

  io_volt_a: assert property (conv_assigned[IO_SUPPLY_BIT] |=>
    conv_voltage[IO_SUPPLY_BIT] == $past(conv_reg_volt[IO_SUPPLY_BIT]))
    else $error("I/O converter voltage wrong");

  rd_idle_zero_a: assert property (!rd_en |=> rd_data == '0)
    else $error("read data not zero without a read");

  unmapped_read_a: assert property (rd_en && !sel_smps && !sel_linreg |=> rd_data == '0)
    else $error("unmapped read not zero");

  write_ignored_a: assert property (wr_en && !sel_smps && !sel_linreg |=>
    $stable(smps_pin1_assign_r) && $stable(linreg_pin2_assign_r))
    else $error("unmapped write changed a register");

  linreg_lp_high_a: assert property (linreg_pin2_assign_r[7] && enable_pin_two |=> !linreg_low_power[7])
    else $error("regulator low-power with pin high");

  io_unassigned_a: assert property (!conv_assigned[IO_SUPPLY_BIT] |=>
    conv_low_power[IO_SUPPLY_BIT] == $past(conv_reg_lp[IO_SUPPLY_BIT]))
    else $error("unassigned I/O converter not register driven");

  linreg_sleep_a: assert property (linreg_pin2_assign_r[5] && !enable_pin_two && !sleep_keep_linreg_on[5]
    |=> !linreg_on[5] && !linreg_low_power[5])
    else $error("regulator not fully off with pin low");

  linreg_serial_a: assert property ((|linreg_pin2_assign_r) |=> !voltage_scaling_serial_port_enable)
    else $error("regulator assignment left serial port on");

  spare_serial_a: assert property (smps_pin1_assign_r[SPARE_BIT] |=> !voltage_scaling_serial_port_enable)
    else $error("spare bit left serial port on");

endmodule : enable_pin_assign

/* pin_host_model.sv */
// Behavioural host that drives the two multiplexed enable pins.
// Assumes the host updates its pin levels just after a rising clk edge.
`timescale 1ns/1ps
module pin_host_model (
  input wire logic clk,
  input wire logic level_one_req,
  input wire logic level_two_req,
  output logic enable_pin_one,
  output logic enable_pin_two
);
  // Both pins start low so that no supply is woken before software asks.
  initial
  begin
    enable_pin_one = 1'b0;
    enable_pin_two = 1'b0;
  end

  // The requested levels appear one edge later, as from a host output register.
  always @(posedge clk)
  begin
    enable_pin_one <= level_one_req;
    enable_pin_two <= level_two_req;
  end
endmodule : pin_host_model

/* tb_enable_pin_assign.sv */
// Self-checking bench for the enable pin supply assignment block.
// Assumes the pin host model and the package from the design folder.
`timescale 1ns/1ps
module tb_enable_pin_assign;
  import enpin_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] rv;
  logic pin_one_req = 1'b0;
  logic pin_two_req = 1'b0;
  logic enable_pin_one;
  logic enable_pin_two;
  logic [CONV_N-1:0] keep_conv = 4'h0;
  logic [LINREG_N-1:0] keep_lin = 8'h00;
  logic [7:0] core1_alt = 8'h00;
  logic [7:0] ext_alt = 8'h15;
  logic [CONV_N-1:0] conv_ron = 4'h6;
  logic [CONV_N-1:0] conv_rlp = 4'h9;
  logic [LINREG_N-1:0] lin_ron = 8'h3C;
  logic [LINREG_N-1:0] lin_rlp = 8'hC3;
  logic [CONV_N-1:0][7:0] reg_volt = {8'h0C, 8'h0B, 8'h0A, 8'h09};
  logic [CONV_N-1:0] conv_on;
  logic [CONV_N-1:0] conv_lp;
  logic [CONV_N-1:0][7:0] conv_volt;
  logic [LINREG_N-1:0] lin_on;
  logic [LINREG_N-1:0] lin_lp;
  logic serial_en;
  int bad_count = 0;
  int check_count = 0;

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  pin_host_model pin_host_model_inst (.clk(clk), .level_one_req(pin_one_req), .level_two_req(pin_two_req),
    .enable_pin_one(enable_pin_one), .enable_pin_two(enable_pin_two));

  enable_pin_assign #(.VOLT_W(8)) enable_pin_assign_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .enable_pin_one(enable_pin_one),
    .enable_pin_two(enable_pin_two), .sleep_keep_converter_on(keep_conv), .sleep_keep_linreg_on(keep_lin),
    .ext_fet_operating_voltage(8'h3A), .ext_fet_alternate_voltage(ext_alt), .core1_operating_voltage(8'h21),
    .core1_alternate_voltage(core1_alt), .core2_operating_voltage(8'h44), .core2_alternate_voltage(8'h12),
    .conv_reg_on(conv_ron), .conv_reg_lp(conv_rlp), .conv_reg_volt(reg_volt), .linreg_reg_on(lin_ron),
    .linreg_reg_lp(lin_rlp), .conv_on(conv_on), .conv_low_power(conv_lp), .conv_voltage(conv_volt),
    .linreg_on(lin_on), .linreg_low_power(lin_lp), .voltage_scaling_serial_port_enable(serial_en));

  // Compare tasks count every check and report each mismatch at once.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  // Register port cycles: one strobe cycle each, read data taken in the cycle after.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : reg_read

  // Write followed at once by a read of the same address, with no idle cycle between the strobes.
  task automatic reg_write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    q = rd_data;
  endtask : reg_write_read

  // Pin requests pass the host register and the design register before they show.
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic test_reset_values;
    reg_write(8'h50, 8'hFF);
    reg_read(SMPS_PIN1_ASSIGN_OFS, rv);
    chk8(rv, 8'h00);
    reg_read(LINREG_PIN2_ASSIGN_OFS, rv);
    chk8(rv, 8'h00);
    reg_read(8'h50, rv);
    chk8(rv, 8'h00);
    chk8({7'h00, serial_en}, 8'h01);
  endtask : test_reset_values

  task automatic test_layout_and_bypass;
    pin_one_req <= 1'b1;
    pin_two_req <= 1'b1;
    reg_write_read(SMPS_PIN1_ASSIGN_OFS, 8'hFF, rv);
    chk8(rv, 8'h1F);
    reg_write(SMPS_PIN1_ASSIGN_OFS, 8'h10);
    settle();
    chk8({7'h00, serial_en}, 8'h00);
    chk8({conv_on, conv_lp}, 8'h69);
    chk32(conv_volt, 32'h0C0B0A09);
    reg_write(SMPS_PIN1_ASSIGN_OFS, 8'h00);
    settle();
    chk8({7'h00, serial_en}, 8'h01);
    chk8({conv_on, conv_lp}, 8'h69);
    chk8(lin_on, 8'h3C);
    chk8(lin_lp, 8'hC3);
    conv_ron <= 4'h9;
    conv_rlp <= 4'h6;
    settle();
    chk8({conv_on, conv_lp}, 8'h96);
  endtask : test_layout_and_bypass

  task automatic test_converters;
    keep_conv <= 4'hF;
    reg_write(SMPS_PIN1_ASSIGN_OFS, 8'h0F);
    settle();
    chk32(conv_volt, 32'h3A442109);
    chk8({conv_on, conv_lp}, 8'hF0);
    pin_one_req <= 1'b0;
    settle();
    chk32(conv_volt, 32'h15120009);
    chk8({conv_on, conv_lp}, 8'hD5);
    keep_conv <= 4'h0;
    core1_alt <= 8'h1E;
    settle();
    chk32(conv_volt, 32'h15121E09);
    chk8({conv_on, conv_lp}, 8'hE0);
    chk8({7'h00, serial_en}, 8'h00);
    ext_alt <= 8'h00;
    keep_conv <= 4'h2;
    settle();
    chk32(conv_volt, 32'h00121E09);
    chk8({conv_on, conv_lp}, 8'h62);
  endtask : test_converters

  task automatic test_linregs;
    reg_write(SMPS_PIN1_ASSIGN_OFS, 8'h00);
    reg_write_read(LINREG_PIN2_ASSIGN_OFS, 8'hA5, rv);
    chk8(rv, 8'hA5);
    keep_lin <= 8'h0F;
    settle();
    chk8(lin_on, 8'hBD);
    chk8(lin_lp, 8'h42);
    chk8({7'h00, serial_en}, 8'h00);
    pin_two_req <= 1'b0;
    settle();
    chk8(lin_on, 8'h1D);
    chk8(lin_lp, 8'h47);
    lin_ron <= 8'hC3;
    lin_rlp <= 8'h3C;
    settle();
    chk8(lin_on, 8'h47);
    chk8(lin_lp, 8'h1D);
  endtask : test_linregs

  task automatic test_turnoff_reset;
    reg_write(SMPS_PIN1_ASSIGN_OFS, 8'h1F);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    reg_read(SMPS_PIN1_ASSIGN_OFS, rv);
    chk8(rv, 8'h00);
    reg_read(LINREG_PIN2_ASSIGN_OFS, rv);
    chk8(rv, 8'h00);
    chk8({7'h00, serial_en}, 8'h01);
  endtask : test_turnoff_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // Main sequence after 20 cycles of reset.
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    test_reset_values();
    test_layout_and_bypass();
    test_converters();
    test_linregs();
    test_turnoff_reset();
    results();
  end

  // Watchdog well beyond the roughly 80 cycles the tests need.
  initial
  begin
    #(2000 * 100);
    bad_count++;
    results();
  end
endmodule : tb_enable_pin_assign
